// ==== hw/ssr_pkg.sv ====
// Package for the segment selector and segment register unit.
// Assumes a single core clock domain and a synchronous active-low reset.
`default_nettype none
package ssr_pkg;

   // ------------------------------------------------------------
   // Selector layout
   // ------------------------------------------------------------
   localparam int SEL_W        = 16;
   localparam int SEL_IDX_HI   = 15;
   localparam int SEL_IDX_LO   = 3;
   localparam int SEL_TS_BIT   = 2;
   localparam int SEL_RL_HI    = 1;
   localparam int SEL_RL_LO    = 0;
   localparam int DESC_SHIFT   = 3;

   // ------------------------------------------------------------
   // Segment register encodings
   // ------------------------------------------------------------
   localparam logic [2:0] SEG_STR  = 3'h0;
   localparam logic [2:0] SEG_CODE = 3'h1;
   localparam logic [2:0] SEG_STK  = 3'h2;
   localparam logic [2:0] SEG_DATA = 3'h3;
   localparam logic [2:0] SEG_ALT1 = 3'h4;
   localparam logic [2:0] SEG_ALT2 = 3'h5;
   localparam int         NUM_SEG  = 6;

   // ------------------------------------------------------------
   // Model-specific register addresses of the two alternate bases
   // ------------------------------------------------------------
   localparam logic [31:0] ALT_DATA_BASE_ONE_ADDR = 32'hC000_0100;
   localparam logic [31:0] ALT_DATA_BASE_TWO_ADDR = 32'hC000_0101;

   localparam logic [1:0]  LEVEL_KERNEL = 2'h0;
   localparam logic [1:0]  LEVEL_USER   = 2'h3;
   localparam int          CANON_HI     = 47;
   localparam logic [63:0] LOW32_MASK   = 64'h0000_0000_FFFF_FFFF;

   // Access kinds for address generation
   localparam logic [1:0] ACC_DATA  = 2'h0;
   localparam logic [1:0] ACC_STR   = 2'h1;
   localparam logic [1:0] ACC_STACK = 2'h2;
   localparam logic [1:0] ACC_FETCH = 2'h3;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [63:0] base;
      logic [31:0] limit;
      logic [11:0] attr;
      logic [1:0]  dlevel;
   } ssr_desc_s;

   typedef struct packed {
      logic [15:0] sel;
      ssr_desc_s   desc;
   } ssr_seg_s;

   typedef struct packed {
      logic        valid;
      logic [2:0]  seg;
      logic [15:0] sel;
   } ssr_load_s;

   typedef struct packed {
      logic        valid;
      logic [1:0]  kind;
      logic        override;
      logic [2:0]  seg;
      logic [63:0] offset;
   } ssr_agen_s;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WRITE} ssr_state_e;

endpackage

`default_nettype wire

// ==== hw/ssr_unit.sv ====
// Segment selector decode, six segment registers with hidden caches,
// null checks, alternate-base writes and segmented address generation.
// Assumes the core supplies descriptor-table bases, a memory port that
// answers one descriptor fetch at a time, and canonical-form checking here.
`timescale 1ns/1ps
`default_nettype none

module ssr_unit (
   input  wire logic              CLK,            // Core clock
   input  wire logic              RST_N,          // Synchronous reset, low
   input  wire logic              MODE_64,        // 64-bit mode active
   input  wire logic              USER_BASE_WR_EN,// user_base_write_enable
   input  wire logic [63:0]       GLOBAL_BASE,    // Global table base
   input  wire logic [63:0]       LOCAL_BASE,     // Local table base
   input  wire ssr_pkg::ssr_load_s LOAD,          // Selector load request
   output logic                   LOAD_BUSY,      // Load in progress
   output logic                   DESC_REQ,       // Descriptor fetch request
   output logic [63:0]            DESC_ADDR,      // Descriptor entry address
   input  wire logic              DESC_ACK,       // Fetch answered
   input  wire ssr_pkg::ssr_desc_s DESC_DATA,     // Decoded descriptor
   input  wire logic              MSR_WR,         // model_reg_write strobe
   input  wire logic [31:0]       MSR_ADDR,       // Model register address
   input  wire logic [63:0]       MSR_DATA,       // Model register data
   input  wire logic              UBW_VALID,      // User base write strobe
   input  wire logic              UBW_TWO,        // 0: alt one, 1: alt two
   input  wire logic              UBW_OP32,       // 32-bit operand
   input  wire logic [63:0]       UBW_DATA,       // General register value
   input  wire ssr_pkg::ssr_agen_s AGEN,          // Address request
   output logic                   ADDR_VALID,     // Linear address valid
   output logic [63:0]            ADDR_OUT,       // Linear address
   output logic [1:0]             REQ_LEVEL,      // Requestor level of load
   output logic [1:0]             CUR_LEVEL,      // current_level
   output logic [15:0]            SEL_OUT [6],    // Visible selectors
   output logic [63:0]            ALT_BASE_ONE,   // alt_data_base_one
   output logic [63:0]            ALT_BASE_TWO,   // alt_data_base_two
   output logic                   FAULT,          // protection_fault pulse
   output logic [15:0]            FAULT_SEL       // Offending selector
);
   import ssr_pkg::*;

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   ssr_seg_s   seg_reg [NUM_SEG];
   ssr_state_e state_reg;
   ssr_load_s  pend_reg;
   logic [1:0] cur_level_reg;
   logic       fault_next;
   logic [15:0] fault_sel_next;

   // ------------------------------------------------------------
   // Selector decode of the incoming load
   // ------------------------------------------------------------
   logic [12:0] ld_index;
   logic        ld_table;
   logic        ld_null;
   logic        ld_bad_seg;
   logic        ld_fault;
   logic [63:0] ld_addr;

   assign ld_index = LOAD.sel[SEL_IDX_HI:SEL_IDX_LO];
   assign ld_table = LOAD.sel[SEL_TS_BIT];
   // Local selector with index zero is a real entry
   assign ld_null  = (ld_index == 13'h0000) && !ld_table;
   assign ld_bad_seg = (LOAD.seg > SEG_ALT2);
   // Index always scaled by eight, also for 16-byte entries
   assign ld_addr  = (ld_table ? LOCAL_BASE : GLOBAL_BASE)
                   + {48'h0, ld_index, 3'h0};
   assign ld_fault = ld_null && ((LOAD.seg == SEG_CODE) ||
                     (LOAD.seg == SEG_STK && (!MODE_64 ||
                      cur_level_reg == LEVEL_USER)));

   function automatic logic canon(input logic [63:0] a);
      canon = (a[63:CANON_HI] == '0) || (a[63:CANON_HI] == '1);
   endfunction

   // ------------------------------------------------------------
   // Load sequencer
   // ------------------------------------------------------------
   logic load_take;
   assign load_take = LOAD.valid && (state_reg == ST_IDLE) && !ld_bad_seg;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_reg <= ST_IDLE;
         pend_reg  <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               // Null loads skip the fetch: no memory behind them
               if (load_take && !ld_fault && !ld_null) begin
                  state_reg <= ST_FETCH;
                  pend_reg  <= LOAD;
               end
            end
            ST_FETCH: begin
               if (DESC_ACK) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         DESC_REQ  <= 1'b0;
         DESC_ADDR <= '0;
         LOAD_BUSY <= 1'b0;
         REQ_LEVEL <= LEVEL_KERNEL;
      end else begin
         if (load_take && !ld_fault && !ld_null) begin
            DESC_REQ  <= 1'b1;
            DESC_ADDR <= ld_addr;
            LOAD_BUSY <= 1'b1;
         end else if (state_reg == ST_FETCH && DESC_ACK) begin
            DESC_REQ  <= 1'b0;
            LOAD_BUSY <= 1'b0;
         end
         if (load_take) begin
            REQ_LEVEL <= LOAD.sel[SEL_RL_HI:SEL_RL_LO];
         end
      end
   end

   // ------------------------------------------------------------
   // Segment registers; mode changes never touch them
   // ------------------------------------------------------------
   logic msr_one;
   logic msr_two;
   logic ubw_ok;
   logic [63:0] ubw_val;
   logic msr_ok;

   assign msr_ok  = MSR_WR && (cur_level_reg == LEVEL_KERNEL)
                  && canon(MSR_DATA);
   assign msr_one = msr_ok && (MSR_ADDR == ALT_DATA_BASE_ONE_ADDR);
   assign msr_two = msr_ok && (MSR_ADDR == ALT_DATA_BASE_TWO_ADDR);
   assign ubw_val = UBW_OP32 ? (UBW_DATA & LOW32_MASK) : UBW_DATA;
   assign ubw_ok  = UBW_VALID && USER_BASE_WR_EN && MODE_64
                  && canon(ubw_val);

   genvar g;
   generate
      for (g = 0; g < NUM_SEG; g++) begin : g_seg
         localparam logic [2:0] ID = 3'(g);
         logic fill;
         logic null_ld;
         logic base_wr;
         logic [63:0] base_val;
         assign fill    = (state_reg == ST_FETCH) && DESC_ACK
                        && (pend_reg.seg == ID);
         assign null_ld = load_take && ld_null && !ld_fault
                        && (LOAD.seg == ID);
         // Only the alternate bases are writable by software
         assign base_wr = (ID == SEG_ALT1) ? (msr_one || (ubw_ok && !UBW_TWO)) :
                          (ID == SEG_ALT2) ? (msr_two || (ubw_ok && UBW_TWO)) :
                          1'b0;
         // Model write only wins for its own segment
         assign base_val = ((ID == SEG_ALT1) ? msr_one : msr_two) ? MSR_DATA : ubw_val;

         always_ff @(posedge CLK) begin
            if (!RST_N) begin
               seg_reg[g] <= '0;
            end else if (fill) begin
               seg_reg[g].sel  <= pend_reg.sel;
               seg_reg[g].desc <= DESC_DATA;
               if (ID == SEG_ALT1 || ID == SEG_ALT2) begin
                  seg_reg[g].desc.base <= DESC_DATA.base & LOW32_MASK;
               end
            end else begin
               // Hidden part kept on a null load; a base write still lands
               if (null_ld) begin
                  seg_reg[g].sel <= LOAD.sel;
               end
               if (base_wr) begin
                  seg_reg[g].desc.base <= base_val;
               end
            end
         end

         always_ff @(posedge CLK) begin
            if (!RST_N) begin
               SEL_OUT[g] <= '0;
            end else if (fill) begin
               SEL_OUT[g] <= pend_reg.sel;
            end else if (null_ld) begin
               SEL_OUT[g] <= LOAD.sel;
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cur_level_reg <= LEVEL_KERNEL;
      end else if (state_reg == ST_FETCH && DESC_ACK && pend_reg.seg == SEG_CODE) begin
         cur_level_reg <= DESC_DATA.dlevel;
      end
   end
   assign CUR_LEVEL = cur_level_reg;

   assign ALT_BASE_ONE = seg_reg[SEG_ALT1].desc.base;
   assign ALT_BASE_TWO = seg_reg[SEG_ALT2].desc.base;

   // ------------------------------------------------------------
   // Address generation
   // ------------------------------------------------------------
   logic [2:0]  ag_seg;
   logic [63:0] ag_base;
   logic        ag_null;
   logic        ag_canon_fault;
   logic [63:0] ag_sum;

   always_comb begin
      case (AGEN.kind)
         ACC_STR:   ag_seg = SEG_STR;
         ACC_STACK: ag_seg = SEG_STK;
         ACC_FETCH: ag_seg = SEG_CODE;
         default:   ag_seg = SEG_DATA;
      endcase
      if (AGEN.override && AGEN.kind != ACC_FETCH && AGEN.seg <= SEG_ALT2) begin
         ag_seg = AGEN.seg;
      end
   end

   always_comb begin
      if (MODE_64) begin
         // Only the alternate bases survive in 64-bit mode
         ag_base = (ag_seg == SEG_ALT1 || ag_seg == SEG_ALT2)
                 ? seg_reg[ag_seg].desc.base : 64'h0;
      end else begin
         ag_base = seg_reg[ag_seg].desc.base & LOW32_MASK;
      end
   end

   assign ag_null = (seg_reg[ag_seg].sel[SEL_IDX_HI:SEL_TS_BIT] == 14'h0000);
   assign ag_sum  = ag_base + AGEN.offset;
   assign ag_canon_fault = MODE_64 && !canon(ag_sum);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ADDR_VALID <= 1'b0;
         ADDR_OUT   <= '0;
      end else begin
         ADDR_VALID <= AGEN.valid && !(ag_null && !MODE_64) && !ag_canon_fault;
         ADDR_OUT   <= MODE_64 ? ag_sum : (ag_sum & LOW32_MASK);
      end
   end

   // ------------------------------------------------------------
   // Fault reporting
   // ------------------------------------------------------------
   always_comb begin
      fault_next     = 1'b0;
      fault_sel_next = '0;
      if (load_take && ld_fault) begin
         fault_next     = 1'b1;
         fault_sel_next = LOAD.sel;
      end else if (AGEN.valid && ag_null && !MODE_64) begin
         fault_next     = 1'b1;
         fault_sel_next = seg_reg[ag_seg].sel;
      end else if ((UBW_VALID && USER_BASE_WR_EN && MODE_64 && !canon(ubw_val))
                || (MSR_WR && !canon(MSR_DATA) &&
                    (MSR_ADDR == ALT_DATA_BASE_ONE_ADDR ||
                     MSR_ADDR == ALT_DATA_BASE_TWO_ADDR))) begin
         fault_next     = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         FAULT     <= 1'b0;
         FAULT_SEL <= '0;
      end else begin
         FAULT     <= fault_next;
         FAULT_SEL <= fault_sel_next;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_load_req;
      load_take && !ld_fault && !ld_null;
   endsequence

   a_entry_address: assert property (@(posedge CLK) disable iff (!RST_N)
      s_load_req |=> DESC_ADDR == $past(ld_addr))
      else $error("descriptor address wrong");
   a_table_pick: assert property (@(posedge CLK) disable iff (!RST_N)
      s_load_req |=> DESC_ADDR == {48'h0, $past(LOAD.sel[SEL_IDX_HI:SEL_IDX_LO]), 3'h0}
         + ($past(LOAD.sel[SEL_TS_BIT]) ? $past(LOCAL_BASE) : $past(GLOBAL_BASE)))
      else $error("table select wrong");
   a_level_out: assert property (@(posedge CLK) disable iff (!RST_N)
      load_take |=> REQ_LEVEL == $past(LOAD.sel[SEL_RL_HI:SEL_RL_LO]))
      else $error("requestor level wrong");
   a_null_code: assert property (@(posedge CLK) disable iff (!RST_N)
      load_take && ld_null && LOAD.seg == SEG_CODE |=> FAULT)
      else $error("null code load not faulted");
   a_local_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      load_take && ld_table && ld_index == 13'h0000
      |=> DESC_REQ ##0 !(FAULT && FAULT_SEL == $past(LOAD.sel)))
      else $error("local index zero treated as null");
   a_code_level: assert property (@(posedge CLK) disable iff (!RST_N)
      state_reg == ST_FETCH && DESC_ACK && pend_reg.seg == SEG_CODE
      |=> CUR_LEVEL == $past(DESC_DATA.dlevel))
      else $error("current level not updated");
   a_alt_clear_high: assert property (@(posedge CLK) disable iff (!RST_N)
      state_reg == ST_FETCH && DESC_ACK && pend_reg.seg == SEG_ALT1
      |=> ALT_BASE_ONE[63:32] == 32'h0)
      else $error("alternate base high half kept");
   a_null_keep: assert property (@(posedge CLK) disable iff (!RST_N)
      load_take && ld_null && LOAD.seg == SEG_ALT1 && !msr_one && !(ubw_ok && !UBW_TWO)
      |=> $stable(ALT_BASE_ONE))
      else $error("null load altered hidden base");
   a_fault_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
      load_take && ld_fault |=> FAULT && FAULT_SEL == $past(LOAD.sel))
      else $error("fault not tied to cause");
   a_msr_write: assert property (@(posedge CLK) disable iff (!RST_N)
      msr_two && !(state_reg == ST_FETCH && DESC_ACK)
      |=> ALT_BASE_TWO == $past(MSR_DATA))
      else $error("model write not taken");

endmodule

`default_nettype wire

// ==== testbench/ssr_desc_mem.sv ====
// Descriptor-table responder standing in for memory behind the unit.
// Assumes one fetch at a time; SLOW picks a prompt or a late answer.
`timescale 1ns/1ps
`default_nettype none
module ssr_desc_mem (
   input  wire logic              CLK,       // Core clock
   input  wire logic              RST_N,     // Synchronous reset, low
   input  wire logic              SLOW,      // Answer three cycles late
   input  wire logic              DESC_REQ,  // Fetch request
   input  wire logic [63:0]       DESC_ADDR, // Entry address
   output logic                   DESC_ACK,  // One-cycle answer
   output var ssr_pkg::ssr_desc_s DESC_DATA  // Entry contents
);
   import ssr_pkg::*;
   logic [1:0] wait_reg;

   // Entry contents follow the address so the bench can predict them
   function automatic ssr_desc_s entry(input logic [63:0] a);
      return '{base: {~a[31:0], a[31:0]}, limit: 32'hFFFF_FFFF, attr: 12'hA5A, dlevel: a[4:3]};
   endfunction

   always_ff @(posedge CLK) begin
      if (!RST_N || !DESC_REQ || DESC_ACK) begin
         wait_reg <= 2'h0;
         DESC_ACK <= 1'b0;
      end else if (wait_reg == (SLOW ? 2'h3 : 2'h0)) begin
         DESC_ACK <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 2'h1;
      end
   end

   // Outside the answer cycle show junk, never a stale entry
   assign DESC_DATA = DESC_ACK ? entry(DESC_ADDR) : ~entry(DESC_ADDR);
endmodule
`default_nettype wire

// ==== testbench/tb_segment_selector_register_unit.sv ====
// Self-checking bench for the segment unit with a descriptor responder.
// Assumes 50 MHz core clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_segment_selector_register_unit;
   import ssr_pkg::*;
   logic        clk = 0, rst_n = 0, mode_64 = 0, ubw_en = 0, slow = 0;
   logic [63:0] gbase = 64'h1000, lbase = 64'h2000;
   ssr_load_s   load = '0;
   ssr_agen_s   agen = '0;
   logic        msr_wr = 0, ubw_valid = 0, ubw_two = 0, ubw_op32 = 0;
   logic [31:0] msr_addr = 0;
   logic [63:0] msr_data = 0, ubw_data = 0;
   logic        load_busy, desc_req, desc_ack, addr_valid, fault;
   logic [63:0] desc_addr, addr_out, alt1, alt2;
   ssr_desc_s   desc_data;
   logic [1:0]  req_level, cur_level;
   logic [15:0] sel_out [6];
   logic [15:0] fault_sel, last_fsel;
   int          miscompares = 0, samples_checked = 0, fault_cnt = 0;

   always #10 clk = ~clk;

   ssr_unit u_dut (.CLK(clk), .RST_N(rst_n), .MODE_64(mode_64), .USER_BASE_WR_EN(ubw_en),
      .GLOBAL_BASE(gbase), .LOCAL_BASE(lbase), .LOAD(load), .LOAD_BUSY(load_busy),
      .DESC_REQ(desc_req), .DESC_ADDR(desc_addr), .DESC_ACK(desc_ack), .DESC_DATA(desc_data),
      .MSR_WR(msr_wr), .MSR_ADDR(msr_addr), .MSR_DATA(msr_data), .UBW_VALID(ubw_valid),
      .UBW_TWO(ubw_two), .UBW_OP32(ubw_op32), .UBW_DATA(ubw_data), .AGEN(agen),
      .ADDR_VALID(addr_valid), .ADDR_OUT(addr_out), .REQ_LEVEL(req_level), .CUR_LEVEL(cur_level),
      .SEL_OUT(sel_out), .ALT_BASE_ONE(alt1), .ALT_BASE_TWO(alt2), .FAULT(fault),
      .FAULT_SEL(fault_sel));

   ssr_desc_mem u_mem (.CLK(clk), .RST_N(rst_n), .SLOW(slow), .DESC_REQ(desc_req),
      .DESC_ADDR(desc_addr), .DESC_ACK(desc_ack), .DESC_DATA(desc_data));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (fault === 1'b1) begin
         fault_cnt++;
         last_fsel = fault_sel;
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic test_done;
      $display("Counts: %0d mismatches in %0d checks", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic do_load(input logic [2:0] seg, input logic [15:0] sel, output logic [63:0] a);
      int n;
      @(negedge clk);
      load = '{1'b1, seg, sel};
      @(negedge clk);
      load.valid = 1'b0;
      a = (desc_req === 1'b1) ? desc_addr : 64'h0;
      if (desc_req === 1'b1) chk(64'(req_level), 64'(sel[1:0]), "requestor level");
      n = 0;
      while (load_busy === 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk(64'(n < 40), 64'h1, "load finished");
      repeat (2) @(negedge clk);
   endtask

   task automatic wr_strobe(input logic msr, input logic [31:0] ad, input logic two,
                            input logic op32, input logic [63:0] d);
      @(negedge clk);
      {msr_wr, msr_addr, msr_data} = {msr, ad, d};
      {ubw_valid, ubw_two, ubw_op32, ubw_data} = {!msr, two, op32, d};
      @(negedge clk);
      {msr_wr, ubw_valid} = 2'b00;
      repeat (2) @(negedge clk);
   endtask

   task automatic agen_chk(input logic [1:0] kind, input logic ovr, input logic [2:0] seg,
                           input logic [63:0] off, input logic v, input logic [63:0] exp);
      @(negedge clk);
      agen = '{1'b1, kind, ovr, seg, off};
      @(negedge clk);
      agen.valid = 1'b0;
      chk(64'(addr_valid), 64'(v), "address valid");
      if (v) chk(addr_out, exp, "linear address");
      @(negedge clk);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_decode;
      logic [63:0] a;
      logic [12:0] idx;
      logic [15:0] s;
      for (int g = 0; g < 6; g++) begin
         idx = (g == 1) ? 13'h4 : (g == 3) ? 13'h1FFF : 13'(g + 1);
         s = {idx, g[0], g[1:0]};
         slow = g[1];
         do_load(3'(g), s, a);
         chk(a, (g[0] ? lbase : gbase) + 64'(idx) * 64'h8, "entry address");
         chk(64'(sel_out[g]), 64'(s), "visible selector");
      end
      chk(64'(cur_level), 64'h0, "level from code entry");
      chk(alt1, 64'h1028, "load clears high base");
      do_load(SEG_DATA, 16'h0004, a);
      chk(a, lbase, "local entry zero");
   endtask

   task automatic t_bases;
      logic [63:0] a;
      int          f0;
      do_load(SEG_ALT1, 16'h0000, a);
      chk(alt1, 64'h1028, "null keeps base");
      wr_strobe(1'b1, ALT_DATA_BASE_TWO_ADDR, 1'b0, 1'b0, 64'hFFFF_8000_1234_5678);
      chk(alt2, 64'hFFFF_8000_1234_5678, "model write");
      f0 = fault_cnt;
      wr_strobe(1'b1, ALT_DATA_BASE_ONE_ADDR, 1'b0, 1'b0, 64'h0000_8000_0000_0000);
      chk(64'(fault_cnt - f0), 64'h1, "non-canonical fault");
      chk(alt1, 64'h1028, "non-canonical refused");
   endtask

   task automatic t_agen;
      mode_64 = 1;
      agen_chk(ACC_DATA, 0, SEG_DATA, 64'hFFFF_FFFF_0000_0040, 1, 64'hFFFF_FFFF_0000_0040);
      agen_chk(ACC_FETCH, 0, SEG_CODE, 64'h40, 1, 64'h40);
      agen_chk(ACC_DATA, 1, SEG_ALT2, 64'h0000_8000_0000_0010, 1, 64'h1234_5688);
      mode_64 = 0;
      chk(alt2, 64'hFFFF_8000_1234_5678, "mode switch keeps base");
      chk(64'(sel_out[SEG_CODE]), 64'h0025, "mode switch keeps selector");
      agen_chk(ACC_STACK, 0, SEG_DATA, 64'h10, 1, 64'h1028);
      agen_chk(ACC_STR, 0, SEG_DATA, 64'h10, 1, 64'h1018);
      agen_chk(ACC_DATA, 0, SEG_DATA, 64'h10, 1, 64'h2010);
      agen_chk(ACC_DATA, 1, SEG_ALT2, 64'h10, 1, 64'h1234_5688);
   endtask

   task automatic t_ubw;
      mode_64 = 1;
      wr_strobe(1'b0, 32'h0, 1'b1, 1'b1, 64'hDEAD_BEEF_0000_1000);
      chk(alt2, 64'hFFFF_8000_1234_5678, "user write disabled");
      ubw_en = 1;
      wr_strobe(1'b0, 32'h0, 1'b1, 1'b1, 64'hDEAD_BEEF_0000_1000);
      chk(alt2, 64'h1000, "narrow user write");
      wr_strobe(1'b0, 32'h0, 1'b0, 1'b0, 64'hFFFF_FFFF_FFFF_F000);
      chk(alt1, 64'hFFFF_FFFF_FFFF_F000, "wide user write");
      mode_64 = 0;
      wr_strobe(1'b0, 32'h0, 1'b0, 1'b0, 64'h5000);
      chk(alt1, 64'hFFFF_FFFF_FFFF_F000, "user write outside 64-bit");
   endtask

   task automatic t_null;
      logic [63:0] a;
      int          f0;
      mode_64 = 1;
      f0 = fault_cnt;
      do_load(SEG_STK, 16'h0000, a);
      chk(64'(fault_cnt - f0), 64'h0, "null stack at level 0");
      agen_chk(ACC_STACK, 0, SEG_DATA, 64'h40, 1, 64'h40);
      do_load(SEG_CODE, 16'h001B, a);
      chk(64'(cur_level), 64'h3, "level from code entry");
      wr_strobe(1'b1, ALT_DATA_BASE_TWO_ADDR, 1'b0, 1'b0, 64'h7000);
      chk(alt2, 64'h1000, "model write at level 3");
      do_load(SEG_STK, 16'h0003, a);
      chk(64'(fault_cnt - f0), 64'h1, "null stack at level 3");
      chk(64'(last_fsel), 64'h0003, "fault selector");
      mode_64 = 0;
      do_load(SEG_CODE, 16'h0000, a);
      chk(64'(fault_cnt - f0), 64'h2, "null code load");
      agen_chk(ACC_STACK, 0, SEG_DATA, 64'h40, 0, 64'h0);
      chk(64'(fault_cnt - f0), 64'h3, "null reference fault");
   endtask

   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1;
      t_decode;
      t_bases;
      t_agen;
      t_ubw;
      t_null;
      test_done;
   end

   // Whole run is well under a thousand cycles
   initial begin
      #200000;
      miscompares++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      test_done;
   end
endmodule
`default_nettype wire
